// [rtl/ppm_params.svh]
// Purpose: Constants of the parallel port block: offsets, fields, pin roles.
// Assumes: Included by each design file of the block except the package.
// Notes: Config direction bits: 1 drives the lines, 0 samples them.
//
// Behaviour
// RQ1 - The block offers 24 software-programmable lines toward the connector.
// RQ2 - The lines form three byte-wide ports port_a, port_b and port_c, bits 0 to 7.
// RQ3 - Each port is set to input or output on its own, so mixed use is possible.
// RQ4 - In mode 0 port_c is two plain 4-bit ports with no handshake lines.
// RQ5 - Mode 1 input puts input_full_flag, strobe_in_n and request of port_a on bits 5..3, and strobe, flag and request of port_b on bits 2..0.
// RQ6 - Mode 1 output puts output_full_n and accept of port_a on bits 7..6, request on bit 3, and accept, output_full_n and request of port_b on bits 2..0.
// RQ7 - Mode 2 puts port_a output_full_n, accept, input_full_flag, strobe_in_n and request on bits 7..3, leaving bits 2..0 plain.
// RQ8 - Strobe, accept and output-full lines are active low; input-full and request are active high.
// RQ9 - The far party pulls strobe_in_n low to present data, and the port captures it while low.
// RQ10 - The input_full_flag rises once data sits in the input latch.
// RQ11 - A software write pulls output_full_n low, and the far party answers with accept low.
// RQ12 - The service_request line rises for a transfer needing attention only if its enable is set.
`ifndef PPM_PARAMS_SVH
`define PPM_PARAMS_SVH

// ----------------------------------------
// Register byte addresses
// ----------------------------------------
`define PPM_ADR_PORT_A 8'h00
`define PPM_ADR_PORT_B 8'h04
`define PPM_ADR_PORT_C 8'h08
`define PPM_ADR_CONFIG 8'h0c
`define PPM_ADR_IRQ_STAT 8'h10
`define PPM_ADR_IRQ_MASK 8'h14

// ----------------------------------------
// Config fields and reset values
// ----------------------------------------
`define PPM_CFG_W 10
`define PPM_CFG_RST 10'h000
`define PPM_CFG_AMODE_HI 1
`define PPM_CFG_AMODE_LO 0
`define PPM_CFG_BMODE 2
`define PPM_CFG_ADIR 3
`define PPM_CFG_BDIR 4
`define PPM_CFG_CHDIR 5
`define PPM_CFG_CLDIR 6
`define PPM_CFG_INTE_AI 7
`define PPM_CFG_INTE_AO 8
`define PPM_CFG_INTE_B 9
`define PPM_BYTE_RST 8'h00
`define PPM_BYTE_ONES 8'hff
`define PPM_NIB_ONES 4'hf
`define PPM_EVT_RST 4'h0
`define PPM_WORD_RST 32'h0000_0000

// ----------------------------------------
// Port C bit roles
// ----------------------------------------
`define PPM_PC_OBF_A 7
`define PPM_PC_ACK_A 6
`define PPM_PC_IBF_A 5
`define PPM_PC_STB_A 4
`define PPM_PC_SRQ_A 3
`define PPM_PC_STB_B 2
`define PPM_PC_ACK_B 2
`define PPM_PC_IBF_B 1
`define PPM_PC_OBF_B 1
`define PPM_PC_SRQ_B 0

// ----------------------------------------
// Interrupt status bits
// ----------------------------------------
`define PPM_EV_A_IN 0
`define PPM_EV_A_OUT 1
`define PPM_EV_B_IN 2
`define PPM_EV_B_OUT 3

`endif

// [rtl/ppm_pkg.sv]
// Purpose: Types shared by the parallel port block.
// Assumes: Nothing beyond the language.
// Notes: Mode codes follow from the config field decode in the top.
package ppm_pkg;
    typedef enum logic [1:0] {PPM_MODE0, PPM_MODE1, PPM_MODE2} ppm_mode_e;
    typedef logic [3:0] ppm_evt_t;
    typedef logic [7:0] ppm_byte_t;
endpackage

// [rtl/ppm_hs_port.sv]
// Purpose: Strobed input latch and output holding register of one port.
// Assumes: Handshake pins are synchronous to clk_sys.
// Notes: A set and a clear in one cycle resolve to the set.
`timescale 1ns/1ps
`include "ppm_params.svh"
module ppm_hs_port
(
    // Clock and reset
    input wire logic clk_sys,
    input wire logic reset_n,
    // Mode
    input wire logic in_en,
    input wire logic out_en,
    // Host side
    input wire logic wr,
    input wire ppm_pkg::ppm_byte_t wr_data,
    input wire logic rd,
    // Pins
    input wire ppm_pkg::ppm_byte_t pin_in,
    input wire logic strobe_in_n,
    input wire logic accept_n,
    // State
    output ppm_pkg::ppm_byte_t latch,
    output ppm_pkg::ppm_byte_t out_data,
    output logic input_full_flag,
    output logic output_full_n,
    output logic service_request_in,
    output logic service_request_out,
    output logic ev_in,
    output logic ev_out
);
    import ppm_pkg::*;

    logic stb_q;
    logic ack_q;
    logic capture;
    logic stb_rise;
    logic ack_rise;

    assign capture = in_en && !strobe_in_n; // see RQ8
    assign stb_rise = in_en && strobe_in_n && !stb_q;
    assign ack_rise = out_en && accept_n && !ack_q;
    assign ev_in = capture && !input_full_flag;
    assign ev_out = ack_rise;

    always_ff @(posedge clk_sys)
    begin
        if (!reset_n)
        begin
            stb_q <= 1'b1;
            ack_q <= 1'b1;
        end
        else
        begin
            stb_q <= strobe_in_n;
            ack_q <= accept_n;
        end
    end

    // ----------------------------------------
    // Input side
    // ----------------------------------------
    always_ff @(posedge clk_sys)
    begin
        if (!reset_n)
            latch <= `PPM_BYTE_RST;
        else if (capture)
            latch <= pin_in; // see RQ9
    end

    always_ff @(posedge clk_sys)
    begin
        if (!reset_n)
            input_full_flag <= 1'b0;
        else if (capture)
            input_full_flag <= 1'b1; // see RQ10
        else if (rd)
            input_full_flag <= 1'b0;
    end

    // Request waits for the strobe to end so the latch is stable when read
    always_ff @(posedge clk_sys)
    begin
        if (!reset_n)
            service_request_in <= 1'b0;
        else if (stb_rise && input_full_flag)
            service_request_in <= 1'b1;
        else if (rd || capture)
            service_request_in <= 1'b0;
    end

    // ----------------------------------------
    // Output side
    // ----------------------------------------
    always_ff @(posedge clk_sys)
    begin
        if (!reset_n)
            out_data <= `PPM_BYTE_RST;
        else if (wr)
            out_data <= wr_data;
    end

    always_ff @(posedge clk_sys)
    begin
        if (!reset_n)
            output_full_n <= 1'b1;
        else if (wr)
            output_full_n <= 1'b0; // see RQ11
        // Released outside output handshake, so a plain write leaves nothing pending
        else if (!out_en || !accept_n)
            output_full_n <= 1'b1;
    end

    always_ff @(posedge clk_sys)
    begin
        if (!reset_n)
            service_request_out <= 1'b0;
        else if (ack_rise)
            service_request_out <= 1'b1;
        else if (wr)
            service_request_out <= 1'b0;
    end

    a_capture_fills: assert property (@(posedge clk_sys) disable iff (!reset_n)
        capture |=> input_full_flag && latch == $past(pin_in)) // see RQ10
        else $error("strobe did not fill the input latch");
    a_read_empties: assert property (@(posedge clk_sys) disable iff (!reset_n)
        rd && !capture |=> !input_full_flag)
        else $error("read did not clear the input flag");
    a_write_fills: assert property (@(posedge clk_sys) disable iff (!reset_n)
        wr |=> !output_full_n && out_data == $past(wr_data)) // see RQ11
        else $error("write did not lower output full");
    a_accept_frees: assert property (@(posedge clk_sys) disable iff (!reset_n)
        out_en && !accept_n && !wr |=> output_full_n)
        else $error("accept did not release output full");
endmodule

// [rtl/ppm_irq.sv]
// Purpose: Sticky event status, mask and one level interrupt.
// Assumes: Events are one-cycle pulses.
// Notes: Write one to clear; an event in the clearing cycle survives.
`timescale 1ns/1ps
`include "ppm_params.svh"
module ppm_irq
(
    // Clock and reset
    input wire logic clk_sys,
    input wire logic reset_n,
    // Events and software
    input wire ppm_pkg::ppm_evt_t ev,
    input wire logic clr_we,
    input wire ppm_pkg::ppm_evt_t clr_data,
    input wire logic mask_we,
    input wire ppm_pkg::ppm_evt_t mask_data,
    // State
    output ppm_pkg::ppm_evt_t status,
    output ppm_pkg::ppm_evt_t mask,
    output logic irq
);
    import ppm_pkg::*;

    ppm_evt_t clr;

    assign clr = clr_we ? clr_data : `PPM_EVT_RST;
    assign irq = |(status & mask);

    always_ff @(posedge clk_sys)
    begin
        if (!reset_n)
            status <= `PPM_EVT_RST;
        else
            status <= (status & ~clr) | ev;
    end

    always_ff @(posedge clk_sys)
    begin
        if (!reset_n)
            mask <= `PPM_EVT_RST;
        else if (mask_we)
            mask <= mask_data;
    end

    a_event_sticks: assert property (@(posedge clk_sys) disable iff (!reset_n)
        (ev != `PPM_EVT_RST) |=> ((status & $past(ev)) == $past(ev)))
        else $error("event bit not set in status");
endmodule

// [rtl/ppm_top.sv]
// Purpose: Three-port parallel I/O with mode 0, 1 and 2 handshaking on port_c.
// Assumes: Classic Wishbone slave, all pins synchronous to clk_sys.
// Notes: Pin outputs are registered, so they trail register changes by a cycle.
//
// Design decisions made here: the Wishbone interface to the registers and the register addresses.
`timescale 1ns/1ps
`include "ppm_params.svh"
module ppm_top
(
    // Clock and reset
    input wire logic clk_sys,
    input wire logic reset_n,
    // Wishbone slave
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_we_i,
    input wire logic [7:0] wb_adr_i,
    input wire logic [3:0] wb_sel_i,
    input wire logic [31:0] wb_dat_i,
    output logic [31:0] wb_dat_o,
    output logic wb_ack_o,
    // Port A pins
    input wire ppm_pkg::ppm_byte_t port_a_in,
    output ppm_pkg::ppm_byte_t port_a_out,
    output ppm_pkg::ppm_byte_t port_a_oe_n,
    // Port B pins
    input wire ppm_pkg::ppm_byte_t port_b_in,
    output ppm_pkg::ppm_byte_t port_b_out,
    output ppm_pkg::ppm_byte_t port_b_oe_n,
    // Port C pins
    input wire ppm_pkg::ppm_byte_t port_c_in,
    output ppm_pkg::ppm_byte_t port_c_out,
    output ppm_pkg::ppm_byte_t port_c_oe_n,
    // Interrupt
    output logic irq
);
    import ppm_pkg::*;

    // ----------------------------------------
    // Helpers
    // ----------------------------------------
    function automatic ppm_mode_e mode_of(input logic [1:0] f);
        ppm_mode_e m;
        case (f)
            2'h0: m = PPM_MODE0;
            2'h1: m = PPM_MODE1;
            default: m = PPM_MODE2;
        endcase
        return m;
    endfunction

    function automatic logic [31:0] merge(input logic [31:0] old,
        input logic [31:0] nv, input logic [3:0] sel);
        logic [31:0] r;
        r = old;
        for (int i = 0; i < 4; i++)
        begin
            if (sel[i])
                r[i*8 +: 8] = nv[i*8 +: 8];
        end
        return r;
    endfunction

    // ----------------------------------------
    // Declarations
    // ----------------------------------------
    logic [`PPM_CFG_W-1:0] cfg;
    ppm_byte_t pc_gp;
    logic access;
    logic wr_acc;
    logic rd_acc;
    logic wr_a;
    logic wr_b;
    logic rd_a;
    logic rd_b;
    ppm_mode_e amode;
    logic bm1;
    logic a_in_en;
    logic a_out_en;
    logic b_in_en;
    logic b_out_en;
    ppm_byte_t latch_a;
    ppm_byte_t latch_b;
    ppm_byte_t data_a;
    ppm_byte_t data_b;
    logic ibf_a;
    logic ibf_b;
    logic obf_a_n;
    logic obf_b_n;
    logic ii_a;
    logic io_a;
    logic ii_b;
    logic io_b;
    logic srq_a;
    logic srq_b;
    ppm_evt_t ev;
    ppm_evt_t irq_status;
    ppm_evt_t irq_mask;
    ppm_byte_t next_pa_out;
    ppm_byte_t next_pa_oe_n;
    ppm_byte_t next_pb_out;
    ppm_byte_t next_pb_oe_n;
    ppm_byte_t next_pc_out;
    ppm_byte_t next_pc_oe_n;
    ppm_byte_t rd_pa;
    ppm_byte_t rd_pb;
    ppm_byte_t rd_pc;
    logic [31:0] next_rdata;
    logic [31:0] cfg_word;
    logic [31:0] gp_word;
    logic ev_ai;
    logic ev_ao;
    logic ev_bi;
    logic ev_bo;
    logic [31:0] cfg_merged;
    logic [31:0] gp_merged;

    // ----------------------------------------
    // Bus decode
    // ----------------------------------------
    assign access = wb_cyc_i && wb_stb_i && !wb_ack_o;
    assign wr_acc = access && wb_we_i;
    assign rd_acc = access && !wb_we_i;
    assign wr_a = wr_acc && wb_sel_i[0] && wb_adr_i == `PPM_ADR_PORT_A;
    assign wr_b = wr_acc && wb_sel_i[0] && wb_adr_i == `PPM_ADR_PORT_B;
    assign rd_a = rd_acc && wb_adr_i == `PPM_ADR_PORT_A;
    assign rd_b = rd_acc && wb_adr_i == `PPM_ADR_PORT_B;
    assign cfg_word = {22'h00_0000, cfg};
    assign gp_word = {24'h00_0000, pc_gp};
    assign cfg_merged = merge(cfg_word, wb_dat_i, wb_sel_i);
    assign gp_merged = merge(gp_word, wb_dat_i, wb_sel_i);

    // ----------------------------------------
    // Mode decode
    // ----------------------------------------
    assign amode = mode_of(cfg[`PPM_CFG_AMODE_HI:`PPM_CFG_AMODE_LO]);
    // Mode 2 takes five of port_c's lines, so group B cannot handshake then
    assign bm1 = cfg[`PPM_CFG_BMODE] && amode != PPM_MODE2;
    assign a_in_en = (amode == PPM_MODE1 && !cfg[`PPM_CFG_ADIR]) || amode == PPM_MODE2;
    assign a_out_en = (amode == PPM_MODE1 && cfg[`PPM_CFG_ADIR]) || amode == PPM_MODE2;
    assign b_in_en = bm1 && !cfg[`PPM_CFG_BDIR];
    assign b_out_en = bm1 && cfg[`PPM_CFG_BDIR];

    // ----------------------------------------
    // Handshake engines
    // ----------------------------------------
    ppm_hs_port u_hs_a
    (
        .clk_sys(clk_sys),
        .reset_n(reset_n),
        .in_en(a_in_en),
        .out_en(a_out_en),
        .wr(wr_a),
        .wr_data(wb_dat_i[7:0]),
        .rd(rd_a && a_in_en),
        .pin_in(port_a_in),
        // A line this block still drives is never a strobe: pin enables lag a mode change
        .strobe_in_n(port_c_in[`PPM_PC_STB_A] || !port_c_oe_n[`PPM_PC_STB_A]),
        .accept_n(port_c_in[`PPM_PC_ACK_A] || !port_c_oe_n[`PPM_PC_ACK_A]),
        .latch(latch_a),
        .out_data(data_a),
        .input_full_flag(ibf_a),
        .output_full_n(obf_a_n),
        .service_request_in(ii_a),
        .service_request_out(io_a),
        .ev_in(ev_ai),
        .ev_out(ev_ao)
    );

    ppm_hs_port u_hs_b
    (
        .clk_sys(clk_sys),
        .reset_n(reset_n),
        .in_en(b_in_en),
        .out_en(b_out_en),
        .wr(wr_b),
        .wr_data(wb_dat_i[7:0]),
        .rd(rd_b && b_in_en),
        .pin_in(port_b_in),
        .strobe_in_n(port_c_in[`PPM_PC_STB_B] || !port_c_oe_n[`PPM_PC_STB_B]),
        .accept_n(port_c_in[`PPM_PC_ACK_B] || !port_c_oe_n[`PPM_PC_ACK_B]),
        .latch(latch_b),
        .out_data(data_b),
        .input_full_flag(ibf_b),
        .output_full_n(obf_b_n),
        .service_request_in(ii_b),
        .service_request_out(io_b),
        .ev_in(ev_bi),
        .ev_out(ev_bo)
    );

    // Requests stay low unless software has enabled them
    assign srq_a = (ii_a && cfg[`PPM_CFG_INTE_AI]) || (io_a && cfg[`PPM_CFG_INTE_AO]); // see RQ12
    assign srq_b = (ii_b || io_b) && cfg[`PPM_CFG_INTE_B]; // see RQ12

    assign ev = {ev_bo, ev_bi, ev_ao, ev_ai};

    ppm_irq u_irq
    (
        .clk_sys(clk_sys),
        .reset_n(reset_n),
        .ev(ev),
        .clr_we(wr_acc && wb_sel_i[0] && wb_adr_i == `PPM_ADR_IRQ_STAT),
        .clr_data(wb_dat_i[3:0]),
        .mask_we(wr_acc && wb_sel_i[0] && wb_adr_i == `PPM_ADR_IRQ_MASK),
        .mask_data(wb_dat_i[3:0]),
        .status(irq_status),
        .mask(irq_mask),
        .irq(irq)
    );

    // ----------------------------------------
    // Software registers
    // ----------------------------------------
    always_ff @(posedge clk_sys)
    begin
        if (!reset_n)
            cfg <= `PPM_CFG_RST;
        else if (wr_acc && wb_adr_i == `PPM_ADR_CONFIG)
            cfg <= cfg_merged[`PPM_CFG_W-1:0]; // see RQ3
    end

    always_ff @(posedge clk_sys)
    begin
        if (!reset_n)
            pc_gp <= `PPM_BYTE_RST;
        else if (wr_acc && wb_adr_i == `PPM_ADR_PORT_C)
            pc_gp <= gp_merged[7:0];
    end

    // ----------------------------------------
    // Pin composition
    // ----------------------------------------
    always_comb
    begin
        // Mode 0 lines follow the port direction bit as a whole byte
        next_pa_out = data_a; // see RQ1
        next_pa_oe_n = cfg[`PPM_CFG_ADIR] ? `PPM_BYTE_RST : `PPM_BYTE_ONES; // see RQ3
        if (amode == PPM_MODE2)
            next_pa_oe_n = port_c_in[`PPM_PC_ACK_A] ? `PPM_BYTE_ONES : `PPM_BYTE_RST;
        else if (a_in_en)
            next_pa_oe_n = `PPM_BYTE_ONES;
        next_pb_out = data_b;
        next_pb_oe_n = cfg[`PPM_CFG_BDIR] ? `PPM_BYTE_RST : `PPM_BYTE_ONES; // see RQ3
    end

    always_comb
    begin
        next_pc_out = pc_gp; // see RQ4
        next_pc_oe_n[7:4] = cfg[`PPM_CFG_CHDIR] ? 4'h0 : `PPM_NIB_ONES;
        next_pc_oe_n[3:0] = cfg[`PPM_CFG_CLDIR] ? 4'h0 : `PPM_NIB_ONES;
        if (a_in_en)
        begin
            next_pc_out[`PPM_PC_IBF_A] = ibf_a; // see RQ5
            next_pc_oe_n[`PPM_PC_IBF_A] = 1'b0;
            next_pc_oe_n[`PPM_PC_STB_A] = 1'b1;
        end
        if (a_out_en)
        begin
            next_pc_out[`PPM_PC_OBF_A] = obf_a_n; // see RQ6
            next_pc_oe_n[`PPM_PC_OBF_A] = 1'b0;
            next_pc_oe_n[`PPM_PC_ACK_A] = 1'b1;
        end
        if (a_in_en || a_out_en)
        begin
            next_pc_out[`PPM_PC_SRQ_A] = srq_a; // see RQ7
            next_pc_oe_n[`PPM_PC_SRQ_A] = 1'b0;
        end
        if (bm1)
        begin
            next_pc_out[`PPM_PC_IBF_B] = b_in_en ? ibf_b : obf_b_n; // see RQ5
            next_pc_oe_n[`PPM_PC_IBF_B] = 1'b0;
            next_pc_oe_n[`PPM_PC_STB_B] = 1'b1;
            next_pc_out[`PPM_PC_SRQ_B] = srq_b;
            next_pc_oe_n[`PPM_PC_SRQ_B] = 1'b0;
        end
    end

    always_ff @(posedge clk_sys)
    begin
        if (!reset_n)
        begin
            port_a_out <= `PPM_BYTE_RST;
            port_a_oe_n <= `PPM_BYTE_ONES;
            port_b_out <= `PPM_BYTE_RST;
            port_b_oe_n <= `PPM_BYTE_ONES;
            port_c_out <= `PPM_BYTE_RST;
            port_c_oe_n <= `PPM_BYTE_ONES;
        end
        else
        begin
            port_a_out <= next_pa_out; // see RQ2
            port_a_oe_n <= next_pa_oe_n;
            port_b_out <= next_pb_out;
            port_b_oe_n <= next_pb_oe_n;
            port_c_out <= next_pc_out;
            port_c_oe_n <= next_pc_oe_n;
        end
    end

    // ----------------------------------------
    // Read path
    // ----------------------------------------
    always_comb
    begin
        rd_pa = a_in_en ? latch_a : (cfg[`PPM_CFG_ADIR] ? data_a : port_a_in);
        rd_pb = b_in_en ? latch_b : (cfg[`PPM_CFG_BDIR] ? data_b : port_b_in);
        for (int i = 0; i < 8; i++)
            rd_pc[i] = port_c_oe_n[i] ? port_c_in[i] : port_c_out[i];
        case (wb_adr_i)
            `PPM_ADR_PORT_A: next_rdata = {24'h00_0000, rd_pa};
            `PPM_ADR_PORT_B: next_rdata = {24'h00_0000, rd_pb};
            `PPM_ADR_PORT_C: next_rdata = {24'h00_0000, rd_pc};
            `PPM_ADR_CONFIG: next_rdata = cfg_word;
            `PPM_ADR_IRQ_STAT: next_rdata = {28'h000_0000, irq_status};
            `PPM_ADR_IRQ_MASK: next_rdata = {28'h000_0000, irq_mask};
            default: next_rdata = `PPM_WORD_RST;
        endcase
    end

    // Unmapped addresses still answer, with zero data, so a master never hangs
    always_ff @(posedge clk_sys)
    begin
        if (!reset_n)
            wb_ack_o <= 1'b0;
        else
            wb_ack_o <= access;
    end

    always_ff @(posedge clk_sys)
    begin
        if (!reset_n)
            wb_dat_o <= `PPM_WORD_RST;
        else if (rd_acc)
            wb_dat_o <= next_rdata;
    end

    // ----------------------------------------
    // Checks
    // ----------------------------------------
    a_ack_single: assert property (@(posedge clk_sys) disable iff (!reset_n)
        access |=> wb_ack_o ##1 !wb_ack_o)
        else $error("bus answer not a single cycle");
    a_mode0_drive: assert property (@(posedge clk_sys) disable iff (!reset_n)
        amode == PPM_MODE0 && cfg[`PPM_CFG_ADIR] |=> port_a_oe_n == `PPM_BYTE_RST) // see RQ3
        else $error("port_a not driven as output");
    a_mode0_pc_plain: assert property (@(posedge clk_sys) disable iff (!reset_n)
        amode == PPM_MODE0 && !bm1 |=> port_c_out == $past(pc_gp)) // see RQ4
        else $error("port_c not plain in mode 0");
    a_ibf_on_pin: assert property (@(posedge clk_sys) disable iff (!reset_n)
        a_in_en |=> port_c_out[`PPM_PC_IBF_A] == $past(ibf_a)
        && !port_c_oe_n[`PPM_PC_IBF_A]) // see RQ5
        else $error("input full flag not on port_c bit 5");
    a_obf_on_pin: assert property (@(posedge clk_sys) disable iff (!reset_n)
        a_out_en |=> port_c_out[`PPM_PC_OBF_A] == $past(obf_a_n)
        && port_c_oe_n[`PPM_PC_ACK_A]) // see RQ6
        else $error("output full not on port_c bit 7");
    a_mode2_low_plain: assert property (@(posedge clk_sys) disable iff (!reset_n)
        amode == PPM_MODE2 |=> port_c_out[2:0] == $past(pc_gp[2:0])) // see RQ7
        else $error("port_c low bits not plain in mode 2");
    a_srq_gated: assert property (@(posedge clk_sys) disable iff (!reset_n)
        a_in_en && !cfg[`PPM_CFG_INTE_AI] && !cfg[`PPM_CFG_INTE_AO]
        |=> !port_c_out[`PPM_PC_SRQ_A]) // see RQ12
        else $error("request raised while disabled");
endmodule

// [sim/ppm_far_dev.sv]
// Purpose: Far-side device on the three ports: strobes bytes in, accepts bytes out.
// Assumes: Pins are synchronous to clk_sys; the bench picks the accept delay.
// Notes: After put_a the released port_a data bus shows the inverse of the byte, never a stale copy.
`timescale 1ns/1ps
module ppm_far_dev
(
    // Clock
    input wire logic clk_sys,
    // Design drive
    input wire ppm_pkg::ppm_byte_t a_out,
    input wire ppm_pkg::ppm_byte_t a_oe_n,
    input wire ppm_pkg::ppm_byte_t b_out,
    input wire ppm_pkg::ppm_byte_t b_oe_n,
    input wire ppm_pkg::ppm_byte_t c_out,
    input wire ppm_pkg::ppm_byte_t c_oe_n,
    // Wire levels
    output ppm_pkg::ppm_byte_t a_in,
    output ppm_pkg::ppm_byte_t b_in,
    output ppm_pkg::ppm_byte_t c_in
);
    import ppm_pkg::*;
    ppm_byte_t a_drv = 8'h00;
    ppm_byte_t b_drv = 8'h00;
    ppm_byte_t c_drv = 8'h57;
    int acc_wait = 2;
    int full_cnt = 0;
    // Each line shows the design where it drives, else our own level
    assign a_in = (a_oe_n & a_drv) | (~a_oe_n & a_out);
    assign b_in = (b_oe_n & b_drv) | (~b_oe_n & b_out);
    assign c_in = (c_oe_n & c_drv) | (~c_oe_n & c_out);
    // Strobe is active low and held two cycles with data steady
    task put_a(input ppm_byte_t d);
        @(posedge clk_sys);
        a_drv <= d;
        c_drv[4] <= 1'b0;
        repeat (2) @(posedge clk_sys);
        c_drv[4] <= 1'b1;
        @(posedge clk_sys);
        a_drv <= ~d;
    endtask
    // One accept pulse after acc_wait cycles of output-full low
    always @(posedge clk_sys)
    begin
        full_cnt <= (c_out[7] === 1'b0 && c_oe_n[7] === 1'b0) ? full_cnt + 1 : 0;
        c_drv[6] <= (full_cnt != acc_wait);
    end
endmodule

// [sim/parallel_port_mode_pins_test.sv]
// Purpose: Bus-driven tests of modes 0, 1 and 2 and the interrupt logic.
// Assumes: Classic Wishbone, one request at a time.
// Notes: The group B strobe on port_c bit 2 is driven from here by hand.
`timescale 1ns/1ps
`include "ppm_params.svh"
module parallel_port_mode_pins_test;
    import ppm_pkg::*;
    logic clk_sys, reset_n, cyc, stb, we, ack, irq;
    logic [7:0] adr;
    logic [3:0] sel;
    logic [31:0] wdat, rdat, q;
    ppm_byte_t a_in, a_out, a_oen, b_in, b_out, b_oen, c_in, c_out, c_oen;
    int n_mismatch = 0;
    int n_tests = 0;
    int cycles = 0;
    ppm_top u_ppm_top (.clk_sys(clk_sys), .reset_n(reset_n), .wb_cyc_i(cyc), .wb_stb_i(stb),
        .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(wdat), .wb_dat_o(rdat),
        .wb_ack_o(ack), .port_a_in(a_in), .port_a_out(a_out), .port_a_oe_n(a_oen),
        .port_b_in(b_in), .port_b_out(b_out), .port_b_oe_n(b_oen), .port_c_in(c_in),
        .port_c_out(c_out), .port_c_oe_n(c_oen), .irq(irq));
    ppm_far_dev u_ppm_far_dev (.clk_sys(clk_sys), .a_out(a_out), .a_oe_n(a_oen),
        .b_out(b_out), .b_oe_n(b_oen), .c_out(c_out), .c_oe_n(c_oen), .a_in(a_in),
        .b_in(b_in), .c_in(c_in));
    // ----------------------------------------
    // Tasks
    // ----------------------------------------
    task end_sim;
        $display("comparisons %0d mismatches %0d", n_tests, n_mismatch);
        if (n_mismatch == 0 && n_tests > 0)
            $display("No errors found");
        else
            $display("Errors were found");
        $finish;
    endtask
    task chk(input logic [31:0] g, input logic [31:0] e);
        n_tests++;
        if (g !== e)
        begin
            n_mismatch++;
            $display("[FAIL] t=%0t got %h expected %h", $time, g, e);
        end
    endtask
    task wb(input logic w, input logic [7:0] a, input logic [31:0] d);
        @(posedge clk_sys);
        cyc <= 1'b1;
        stb <= 1'b1;
        we <= w;
        adr <= a;
        wdat <= d;
        @(posedge clk_sys);
        while (ack !== 1'b1) @(posedge clk_sys);
        q = rdat;
        cyc <= 1'b0;
        stb <= 1'b0;
    endtask
    task rd(input logic [7:0] a, input logic [31:0] e);
        wb(1'b0, a, 32'h0000_0000);
        chk(q, e);
    endtask
    // Bounded wait for a port_c pin level, then compare it
    task wpin(input int i, input logic v);
        for (int k = 0; k < 30 && c_out[i] !== v; k++) @(posedge clk_sys);
        chk(c_out[i], v);
    endtask
    initial
    begin
        clk_sys = 1'b0;
        forever #4 clk_sys = ~clk_sys;
    end
    // Run is under two hundred cycles; the ceiling of 4000 leaves wide margin
    always @(posedge clk_sys)
    begin
        cycles++;
        if (cycles == 4000)
        begin
            n_mismatch++;
            end_sim();
        end
    end
    // ----------------------------------------
    // Tests
    // ----------------------------------------
    initial
    begin
        reset_n = 1'b0;
        {cyc, stb, we, adr, wdat} = '0;
        sel = 4'hf;
        repeat (2) @(posedge clk_sys);
        reset_n <= 1'b1;
        @(posedge clk_sys);
        chk(a_oen, 8'hff);
        chk(c_oen, 8'hff);
        rd(`PPM_ADR_CONFIG, 32'h0000_0000);
        rd(8'h3c, 32'h0000_0000);
        $display("test reset done");
        wb(1'b1, `PPM_ADR_CONFIG, 32'h0000_0028);
        u_ppm_far_dev.b_drv <= 8'hc3;
        wb(1'b1, `PPM_ADR_PORT_A, 32'h0000_005a);
        wb(1'b1, `PPM_ADR_PORT_C, 32'h0000_00a5);
        repeat (2) @(posedge clk_sys);
        chk({a_oen, a_out}, 16'h005a);
        chk(b_oen, 8'hff);
        chk(c_oen, 8'h0f);
        rd(`PPM_ADR_PORT_B, 32'h0000_00c3);
        rd(`PPM_ADR_PORT_C, 32'h0000_00a7);
        $display("test mode0 done");
        wb(1'b1, `PPM_ADR_CONFIG, 32'h0000_0081);
        u_ppm_far_dev.put_a(8'h3c);
        wpin(5, 1'b1);
        wpin(3, 1'b1);
        chk(irq, 1'b0);
        wb(1'b1, `PPM_ADR_IRQ_MASK, 32'h0000_0001);
        chk(irq, 1'b1);
        rd(`PPM_ADR_PORT_A, 32'h0000_003c);
        wpin(5, 1'b0);
        wb(1'b1, `PPM_ADR_IRQ_STAT, 32'h0000_0001);
        chk(irq, 1'b0);
        $display("test mode1 input done");
        wb(1'b1, `PPM_ADR_CONFIG, 32'h0000_0109);
        wb(1'b1, `PPM_ADR_IRQ_MASK, 32'h0000_0002);
        // Prompt and slow accept from the far side
        for (int w = 2; w <= 6; w += 4)
        begin
            u_ppm_far_dev.acc_wait <= w;
            wb(1'b1, `PPM_ADR_PORT_A, 32'h0000_0096 + w);
            wpin(7, 1'b0);
            wpin(7, 1'b1);
            wpin(3, 1'b1);
            chk(a_out, 32'h0000_0096 + w);
            chk(irq, 1'b1);
            wb(1'b1, `PPM_ADR_IRQ_STAT, 32'h0000_0002);
            chk(irq, 1'b0);
        end
        $display("test mode1 output done");
        wb(1'b1, `PPM_ADR_CONFIG, 32'h0000_0082);
        u_ppm_far_dev.put_a(8'h77);
        wpin(5, 1'b1);
        chk(c_oen, 8'h57);
        chk(a_oen, 8'hff);
        rd(`PPM_ADR_PORT_A, 32'h0000_0077);
        $display("test mode2 done");
        wb(1'b1, `PPM_ADR_CONFIG, 32'h0000_0204);
        u_ppm_far_dev.b_drv <= 8'h6e;
        u_ppm_far_dev.c_drv[2] <= 1'b0;
        repeat (2) @(posedge clk_sys);
        u_ppm_far_dev.c_drv[2] <= 1'b1;
        wpin(1, 1'b1);
        wpin(0, 1'b1);
        rd(`PPM_ADR_PORT_B, 32'h0000_006e);
        $display("test group b done");
        end_sim();
    end
endmodule
